// ### core/crio_pkg.sv
// constants and carrier types for the remote i/o register block
package crio_pkg;

  // register addresses
  localparam logic [3:0] ADDR_INPUT  = 4'h0;
  localparam logic [3:0] ADDR_RISE   = 4'h1;
  localparam logic [3:0] ADDR_FALL   = 4'h2;
  localparam logic [3:0] ADDR_OUT    = 4'h3;
  localparam logic [3:0] ADDR_DRV    = 4'h4;
  localparam logic [3:0] ADDR_ANALOG = 4'h5;
  localparam logic [3:0] ADDR_PULSE_DAC_ONE   = 4'h6;
  localparam logic [3:0] ADDR_PULSE_DAC_TWO   = 4'h7;
  localparam logic [3:0] ADDR_ADC    = 4'h8;

  // frame acceptance
  localparam logic [3:0] DLC_REG = 4'h3;

  // analog_setup field positions
  localparam int CONV_BIT = 15;
  localparam int OC_LSB   = 12;
  localparam int MON_LSB  = 8;
  localparam int SW_LSB   = 5;

  // pulse modulator and conversion fields
  localparam int DPM_W    = 10;
  localparam int DPM_LSB  = 6;
  localparam int PULSE_CLKS = 4;

  // pins with special functions
  localparam int PIN_PULSE_DAC_ONE = 10;
  localparam int PIN_PULSE_DAC_TWO = 4;
  localparam int MON_PIN [0:2] = '{7, 9, 8};

  // switch codes
  localparam logic [2:0] SW_NONE     = 3'h0;
  localparam logic [2:0] SW_RESERVED = 3'h7;
  localparam logic [5:0] SW_ONE      = 6'h01;

  localparam logic [15:0] REG_CLEAR = 16'h0000;
  localparam logic [15:0] ALL_FLOAT = 16'hffff;

  typedef enum logic [1:0] {
    CRIO_FR_DATA,
    CRIO_FR_REMOTE,
    CRIO_FR_CAL
  } crio_frame_t;

  typedef enum logic [1:0] {
    CRIO_TX_IDLE,
    CRIO_TX_ARB,
    CRIO_TX_BODY
  } crio_txst_t;

  // frame handed over by the protocol engine after it checked valid
  typedef struct packed {
    crio_frame_t kind;
    logic [3:0]  dlc;
    logic        dir;
    logic [3:0]  addr;
    logic [15:0] value;
  } crio_rx_t;

  // frame handed to the protocol engine: status, address, contents
  typedef struct packed {
    logic        rstd;
    logic        ew;
    logic [1:0]  bm;
    logic [3:0]  addr;
    logic [15:0] value;
  } crio_tx_t;

endpackage

// ### core/crio_dpm.sv
// distributed pulse modulator for one quasi-analog output
`timescale 1ns/1ps

module crio_dpm #(
  parameter int W     = crio_pkg::DPM_W,
  parameter int PULSE = crio_pkg::PULSE_CLKS
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // level and modulated output
  input  wire logic [W-1:0] level,
  output logic              pulse
);

  localparam int CW = (PULSE > 1) ? $clog2(PULSE) : 1;
  localparam logic [CW-1:0] LAST = CW'(PULSE - 1);

  typedef struct packed {
    logic [CW-1:0] slot;
    logic [W-1:0]  seq;
    logic          pulse;
  } crio_dpm_st_t;

  crio_dpm_st_t st;
  crio_dpm_st_t next_st;
  logic [W-1:0] rev;

  // bit-reversed sequence spreads the pulses evenly over the period
  for (genvar i = 0; i < W; i++)
  begin : g_rev
    assign rev[i] = st.seq[W-1-i];
  end

  always_comb
  begin
    next_st = st;
    if (st.slot == LAST)
    begin
      next_st.slot = '0;
      next_st.seq  = st.seq + 1'b1;
    end
    else
    begin
      next_st.slot = st.slot + 1'b1;
    end
    if (st.slot == LAST)
    begin
      next_st.pulse = (rev < level);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign pulse = st.pulse;

endmodule

// ### core/crio_regs.sv
// register set and port logic of the remote i/o node
`timescale 1ns/1ps

// Behaviour
// - input_level at 0 reads pin levels; sent on poll or edge
// - edge message loads pin state once control field is sent
// - a later pin change before sending is sent, not the old sample
// - after calibration the input_level contents go out as sign-on
// - rise_capture_cfg at 1: bit set captures rising edges
// - fall_capture_cfg at 2: falling edges; both bits give both edges
// - driver_enable at 4: bit 1 drives pin, 0 floats it
// - output_value at 3 reaches the pins two clocks after the frame is valid
// - convert_start_bit starts conversion, clears after result is sent
// - comparator_state_bits returned on frames addressing analog_setup
// - monitor_route_bits route comparators to pins 7, 9, 8 if driven
// - monitored comparator change with edge and enable sends analog_setup
// - switch_select_bits: 0 none, 1 to 6 one switch, 7 reserved
// - modulator one on pin 10 needs drive enable; output bit inverts
// - value pulses per period, four clocks each, spread evenly
// - pulse_dac_two at 7 drives pin 4 like the first modulator
// - conversion_result at 8; data frame to it starts conversion
// - every length 3 direction 0 data frame except one to conversion_result answered with status, address and contents
// - send length 3 direction 1; accept data, remote, calibration
// - never sends remote frames; overload only as reaction
// - byte one address, bytes two and three value; read-only ignored
module crio_regs #(
  parameter int NPIN = 16
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // received frames
  input  wire logic              rx_valid,
  input  wire crio_pkg::crio_rx_t rx,
  // transmit request
  output logic                   tx_req,
  input  wire logic              tx_ctrl_sent,
  input  wire logic              tx_done,
  output crio_pkg::crio_tx_t     tx,
  // link status
  input  wire logic              calibrated,
  input  wire logic              mode_change,
  input  wire logic              err_warn,
  input  wire logic [1:0]        bus_mode,
  // port pins
  input  wire logic [NPIN-1:0]   pin_in,
  output logic      [NPIN-1:0]   pin_out,
  output logic      [NPIN-1:0]   pin_oe_n,
  // analog section
  input  wire logic [2:0]        cmp_in,
  output logic      [5:0]        sw_close,
  output logic                   adc_start,
  input  wire logic              adc_done,
  input  wire logic [9:0]        adc_result
);

  localparam int W = crio_pkg::DPM_W;

  typedef struct packed {
    logic [NPIN-1:0]     pin_s1;
    logic [NPIN-1:0]     pin_s2;
    logic [NPIN-1:0]     pin_prev;
    logic [2:0]          cmp_s1;
    logic [2:0]          cmp_s2;
    logic [2:0]          cmp_prev;
    logic [NPIN-1:0]     rise_cfg;
    logic [NPIN-1:0]     fall_cfg;
    logic [NPIN-1:0]     out_val;
    logic [NPIN-1:0]     drv_en;
    logic                conv_bit;
    logic [2:0]          mon;
    logic [2:0]          sw;
    logic [W-1:0]        pulse_dac_one;
    logic [W-1:0]        pulse_dac_two;
    logic [W-1:0]        result;
    logic                reply_pend;
    logic [3:0]          reply_addr;
    logic                ana_pend;
    logic                adc_pend;
    logic                in_pend;
    logic                signon;
    logic                conv_after;
    logic                conv_busy;
    logic                adc_go;
    crio_pkg::crio_txst_t txs;
    crio_pkg::crio_tx_t  tx;
    logic [NPIN-1:0]     pout;
    logic [NPIN-1:0]     poe_n;
    logic [5:0]          swc;
  } crio_st_t;

  crio_st_t        st;
  crio_st_t        next_st;
  logic [NPIN-1:0] edge_ev;
  logic [2:0]      cmp_ev;
  logic [NPIN-1:0] drive;
  logic [15:0]     img;
  logic [15:0]     ana_img;
  logic [3:0]      sel_addr;
  logic            sel;
  logic            sel_rstd;
  logic            start_conv;
  logic            pulse_dac_one_pulse;
  logic            pulse_dac_two_pulse;

  crio_dpm #(
    .W     (W),
    .PULSE (crio_pkg::PULSE_CLKS)
  ) u_pulse_dac_one (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .level    (st.pulse_dac_one),
    .pulse    (pulse_dac_one_pulse)
  );

  crio_dpm #(
    .W     (W),
    .PULSE (crio_pkg::PULSE_CLKS)
  ) u_pulse_dac_two (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .level    (st.pulse_dac_two),
    .pulse    (pulse_dac_two_pulse)
  );

  // edge capture per pin
  assign edge_ev = (st.pin_s2 & ~st.pin_prev & st.rise_cfg)
                 | (~st.pin_s2 & st.pin_prev & st.fall_cfg);

  // comparator monitor events and pin routing
  for (genvar k = 0; k < 3; k++)
  begin : g_mon
    localparam int P = crio_pkg::MON_PIN[k];
    assign cmp_ev[k] = st.mon[k] && st.drv_en[P]
      && ((st.rise_cfg[P] && st.cmp_s2[k] && !st.cmp_prev[k])
       || (st.fall_cfg[P] && !st.cmp_s2[k] && st.cmp_prev[k]));
  end

  // output level per pin, before registering
  for (genvar i = 0; i < NPIN; i++)
  begin : g_pin
    if (i == crio_pkg::PIN_PULSE_DAC_ONE)
    begin : g_d1
      assign drive[i] = st.out_val[i] ^ pulse_dac_one_pulse;
    end
    else if (i == crio_pkg::PIN_PULSE_DAC_TWO)
    begin : g_d2
      assign drive[i] = st.out_val[i] ^ pulse_dac_two_pulse;
    end
    else if (i == crio_pkg::MON_PIN[0])
    begin : g_m1
      assign drive[i] = st.mon[0] ? st.cmp_s2[0] : st.out_val[i];
    end
    else if (i == crio_pkg::MON_PIN[1])
    begin : g_m2
      assign drive[i] = st.mon[1] ? st.cmp_s2[1] : st.out_val[i];
    end
    else if (i == crio_pkg::MON_PIN[2])
    begin : g_m3
      assign drive[i] = st.mon[2] ? st.cmp_s2[2] : st.out_val[i];
    end
    else
    begin : g_plain
      assign drive[i] = st.out_val[i];
    end
  end

  // analog_setup image
  always_comb
  begin
    ana_img = crio_pkg::REG_CLEAR;
    ana_img[crio_pkg::CONV_BIT] = st.conv_bit;
    ana_img[crio_pkg::OC_LSB +: 3] = st.cmp_s2;
    ana_img[crio_pkg::MON_LSB +: 3] = st.mon;
    ana_img[crio_pkg::SW_LSB +: 3] = st.sw;
  end

  // contents of the register being sent
  always_comb
  begin
    img = crio_pkg::REG_CLEAR;
    if (st.tx.addr == crio_pkg::ADDR_INPUT)
      img = 16'(st.pin_s2);
    else if (st.tx.addr == crio_pkg::ADDR_RISE)
      img = 16'(st.rise_cfg);
    else if (st.tx.addr == crio_pkg::ADDR_FALL)
      img = 16'(st.fall_cfg);
    else if (st.tx.addr == crio_pkg::ADDR_OUT)
      img = 16'(st.out_val);
    else if (st.tx.addr == crio_pkg::ADDR_DRV)
      img = 16'(st.drv_en);
    else if (st.tx.addr == crio_pkg::ADDR_ANALOG)
      img = ana_img;
    else if (st.tx.addr == crio_pkg::ADDR_PULSE_DAC_ONE)
      img[crio_pkg::DPM_LSB +: W] = st.pulse_dac_one;
    else if (st.tx.addr == crio_pkg::ADDR_PULSE_DAC_TWO)
      img[crio_pkg::DPM_LSB +: W] = st.pulse_dac_two;
    else if (st.tx.addr == crio_pkg::ADDR_ADC)
      img[crio_pkg::DPM_LSB +: W] = st.result;
  end

  // pick the next message: replies, analog, result, inputs
  always_comb
  begin
    sel      = 1'b1;
    sel_rstd = 1'b0;
    sel_addr = crio_pkg::ADDR_INPUT;
    if (st.reply_pend)
      sel_addr = st.reply_addr;
    else if (st.ana_pend)
      sel_addr = crio_pkg::ADDR_ANALOG;
    else if (st.adc_pend)
      sel_addr = crio_pkg::ADDR_ADC;
    else if (st.in_pend)
      sel_rstd = st.signon;
    else
      sel = 1'b0;
  end

  always_comb
  begin
    next_st    = st;
    start_conv = 1'b0;
    next_st.adc_go   = 1'b0;
    next_st.pin_s1   = pin_in;
    next_st.pin_s2   = st.pin_s1;
    next_st.pin_prev = st.pin_s2;
    next_st.cmp_s1   = cmp_in;
    next_st.cmp_s2   = st.cmp_s1;
    next_st.cmp_prev = st.cmp_s2;

    // transmit sequence; only data frames are ever sent
    case (st.txs)
      crio_pkg::CRIO_TX_IDLE:
      begin
        if (sel)
        begin
          next_st.txs     = crio_pkg::CRIO_TX_ARB;
          next_st.tx.rstd = sel_rstd;
          next_st.tx.ew   = err_warn;
          next_st.tx.bm   = bus_mode;
          next_st.tx.addr = sel_addr;
          next_st.tx.value = crio_pkg::REG_CLEAR;
          if (st.reply_pend)
            next_st.reply_pend = 1'b0;
          else if (st.ana_pend)
            next_st.ana_pend = 1'b0;
          else if (st.adc_pend)
            next_st.adc_pend = 1'b0;
          else
          begin
            next_st.in_pend = 1'b0;
            next_st.signon  = 1'b0;
          end
        end
      end
      crio_pkg::CRIO_TX_ARB:
      begin
        if (tx_ctrl_sent)
        begin
          next_st.tx.value = img;
          next_st.txs      = crio_pkg::CRIO_TX_BODY;
        end
      end
      crio_pkg::CRIO_TX_BODY:
      begin
        if (tx_done)
        begin
          next_st.txs = crio_pkg::CRIO_TX_IDLE;
          if (st.tx.addr == crio_pkg::ADDR_ANALOG && st.conv_after)
          begin
            next_st.conv_after = 1'b0;
            start_conv = 1'b1;
          end
          if (st.tx.addr == crio_pkg::ADDR_ADC)
            next_st.conv_bit = 1'b0;
        end
      end
      default:
      begin
        next_st.txs = crio_pkg::CRIO_TX_IDLE;
      end
    endcase

    // received frames
    if (rx_valid)
    begin
      case (rx.kind)
        crio_pkg::CRIO_FR_DATA:
        begin
          if (rx.dlc == crio_pkg::DLC_REG && !rx.dir)
          begin
            if (rx.addr == crio_pkg::ADDR_RISE)
              next_st.rise_cfg = rx.value[NPIN-1:0];
            else if (rx.addr == crio_pkg::ADDR_FALL)
              next_st.fall_cfg = rx.value[NPIN-1:0];
            else if (rx.addr == crio_pkg::ADDR_OUT)
              next_st.out_val = rx.value[NPIN-1:0];
            else if (rx.addr == crio_pkg::ADDR_DRV)
              next_st.drv_en = rx.value[NPIN-1:0];
            else if (rx.addr == crio_pkg::ADDR_ANALOG)
            begin
              next_st.mon = rx.value[crio_pkg::MON_LSB +: 3];
              next_st.sw  = rx.value[crio_pkg::SW_LSB +: 3];
              if (rx.value[crio_pkg::CONV_BIT])
              begin
                next_st.conv_bit   = 1'b1;
                next_st.conv_after = 1'b1;
              end
            end
            else if (rx.addr == crio_pkg::ADDR_PULSE_DAC_ONE)
              next_st.pulse_dac_one = rx.value[crio_pkg::DPM_LSB +: W];
            else if (rx.addr == crio_pkg::ADDR_PULSE_DAC_TWO)
              next_st.pulse_dac_two = rx.value[crio_pkg::DPM_LSB +: W];
            // other addresses are read-only or unmapped
            if (rx.addr == crio_pkg::ADDR_ADC)
              start_conv = 1'b1;
            else
            begin
              next_st.reply_pend = 1'b1;
              next_st.reply_addr = rx.addr;
            end
          end
        end
        crio_pkg::CRIO_FR_REMOTE:
        begin
          if (rx.dlc == crio_pkg::DLC_REG && rx.dir)
            next_st.in_pend = 1'b1;
        end
        default:
        begin
          next_st.in_pend = next_st.in_pend;
        end
      endcase
    end

    // conversion handshake with the converter
    if (start_conv && !st.conv_busy)
    begin
      next_st.adc_go    = 1'b1;
      next_st.conv_busy = 1'b1;
    end
    if (adc_done && st.conv_busy)
    begin
      next_st.result    = adc_result;
      next_st.conv_busy = 1'b0;
      next_st.adc_pend  = 1'b1;
    end

    // events set after the clears so a same-cycle event is kept
    if (|edge_ev)
      next_st.in_pend = 1'b1;
    if (|cmp_ev)
      next_st.ana_pend = 1'b1;
    if (calibrated)
    begin
      next_st.in_pend = 1'b1;
      next_st.signon  = 1'b1;
    end

    // pin and switch drive
    next_st.pout  = drive;
    next_st.poe_n = ~st.drv_en;
    if (st.sw == crio_pkg::SW_NONE || st.sw == crio_pkg::SW_RESERVED)
      next_st.swc = '0;
    else
      next_st.swc = 6'(crio_pkg::SW_ONE << (st.sw - 3'h1));

    // bus mode change returns everything to the fail-safe state
    if (mode_change)
    begin
      next_st.rise_cfg   = '0;
      next_st.fall_cfg   = '0;
      next_st.out_val    = '0;
      next_st.drv_en     = '0;
      next_st.conv_bit   = 1'b0;
      next_st.mon        = '0;
      next_st.sw         = '0;
      next_st.pulse_dac_one       = '0;
      next_st.pulse_dac_two       = '0;
      next_st.result     = '0;
      next_st.reply_pend = 1'b0;
      next_st.ana_pend   = 1'b0;
      next_st.adc_pend   = 1'b0;
      next_st.in_pend    = 1'b0;
      next_st.signon     = 1'b0;
      next_st.conv_after = 1'b0;
      next_st.conv_busy  = 1'b0;
      next_st.adc_go     = 1'b0;
      next_st.txs        = crio_pkg::CRIO_TX_IDLE;
      next_st.poe_n      = crio_pkg::ALL_FLOAT[NPIN-1:0];
      next_st.swc        = '0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st       <= '0;
      st.poe_n <= crio_pkg::ALL_FLOAT[NPIN-1:0];
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs
  assign tx_req    = (st.txs != crio_pkg::CRIO_TX_IDLE);
  assign tx        = st.tx;
  assign pin_out   = st.pout;
  assign pin_oe_n  = st.poe_n;
  assign sw_close  = st.swc;
  assign adc_start = st.adc_go;

endmodule

// ### verification/crio_regs_monitor.sv
// assertion checker on the ports of the remote i/o register block
`timescale 1ns/1ps

module crio_regs_monitor #(
  parameter int NPIN = 16
) (
  input wire logic               core_clk,
  input wire logic               sys_rst,
  input wire logic               rx_valid,
  input wire crio_pkg::crio_rx_t rx,
  input wire logic               calibrated,
  input wire logic               tx_req,
  input wire logic               tx_done,
  input wire crio_pkg::crio_tx_t tx,
  input wire logic [NPIN-1:0]    pin_out,
  input wire logic [NPIN-1:0]    pin_oe_n,
  input wire logic [5:0]         sw_close,
  input wire logic               adc_start
);
  logic wr_ok;

  function automatic logic [5:0] sw_dec(input logic [2:0] c);
    return (c == 3'h0 || c == 3'h7) ? 6'h00 : 6'h01 << (c - 3'h1);
  endfunction

  assign wr_ok = rx_valid && rx.kind == crio_pkg::CRIO_FR_DATA
                 && rx.dlc == crio_pkg::DLC_REG && !rx.dir;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_reply_head: assert property (wr_ok && rx.addr != crio_pkg::ADDR_ADC
    && !tx_req |-> ##2 tx_req && tx.addr == $past(rx.addr, 2))
    else $error("reply frame not started for a data frame");
  a_poll_input: assert property (rx_valid
    && rx.kind == crio_pkg::CRIO_FR_REMOTE && rx.dlc == crio_pkg::DLC_REG
    && rx.dir && !tx_req |-> ##2 tx_req && tx.addr == crio_pkg::ADDR_INPUT)
    else $error("remote frame not answered with input levels");
  a_bad_length: assert property (rx_valid && !tx_req
    && rx.kind == crio_pkg::CRIO_FR_DATA && rx.dlc != crio_pkg::DLC_REG
    |-> ##2 !tx_req)
    else $error("frame with wrong length was answered");
  a_drive_enable: assert property (wr_ok
    && rx.addr == crio_pkg::ADDR_DRV ##1 1'b1
    |=> pin_oe_n == ~$past(rx.value, 2))
    else $error("pin drivers do not follow driver enable");
  a_out_level: assert property (wr_ok && rx.addr == crio_pkg::ADDR_OUT
    |-> ##2 (pin_out & 16'hf86f) == ($past(rx.value, 2) & 16'hf86f))
    else $error("pin levels do not follow output value");
  a_switch_sel: assert property (wr_ok
    && rx.addr == crio_pkg::ADDR_ANALOG
    |-> ##2 sw_close == sw_dec($past(rx.value[7:5], 2)))
    else $error("switch closure does not match its code");
  a_switch_hot: assert property ($onehot0(sw_close))
    else $error("more than one analog switch closed");
  a_adc_kick: assert property (wr_ok && rx.addr == crio_pkg::ADDR_ADC
    && !adc_start |=> adc_start)
    else $error("conversion not started by frame to result");
  a_tx_hold: assert property (tx_req && !tx_done |=> tx_req)
    else $error("frame request dropped before completion");
  a_sign_on: assert property (calibrated && !tx_req
    |-> ##[1:3] tx_req && tx.addr == crio_pkg::ADDR_INPUT && tx.rstd)
    else $error("no sign-on frame after calibration");
endmodule

bind crio_regs crio_regs_monitor #(.NPIN(NPIN)) crio_regs_monitor_i (
  .core_clk(core_clk), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx(rx),
  .calibrated(calibrated), .tx_req(tx_req), .tx_done(tx_done), .tx(tx),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .sw_close(sw_close),
  .adc_start(adc_start));

// ### verification/crio_host_model.sv
// host engine model: paces device frames and keeps the last one sent
`timescale 1ns/1ps

module crio_host_model (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // device frame and pacing
  input  wire logic               tx_req,
  input  wire crio_pkg::crio_tx_t tx,
  input  wire logic [7:0]         ctrl_wait,
  // engine strobes and record
  output logic                    tx_ctrl_sent,
  output logic                    tx_done,
  output crio_pkg::crio_tx_t      last_tx
);
  logic [7:0] cnt;
  logic [1:0] ph;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt          <= 8'h00;
      ph           <= 2'h0;
      tx_ctrl_sent <= 1'b0;
      tx_done      <= 1'b0;
      last_tx      <= '0;
    end
    else
    begin
      tx_ctrl_sent <= 1'b0;
      tx_done      <= 1'b0;
      cnt          <= cnt - 8'h01;
      if (ph == 2'h0 && tx_req)
      begin
        ph  <= 2'h1;
        cnt <= ctrl_wait;
      end
      else if (ph != 2'h0 && cnt == 8'h00)
      begin
        ph           <= ph + 2'h1;
        cnt          <= 8'h14;
        tx_ctrl_sent <= (ph == 2'h1);
        tx_done      <= (ph == 2'h2);
        if (ph == 2'h2)
          last_tx <= tx;
      end
    end
  end
endmodule

// ### verification/crio_regs_test.sv
// self-checking bench for the remote i/o register block
`timescale 1ns/1ps

module crio_regs_test;
  logic               core_clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               rx_valid = 1'b0;
  crio_pkg::crio_rx_t rx = '0;
  logic               calibrated = 1'b0;
  logic               mode_change = 1'b0;
  logic               err_warn = 1'b0;
  logic [1:0]         bus_mode = 2'h0;
  logic [15:0]        pin_in = 16'h1234;
  logic [2:0]         cmp_in = 3'h0;
  logic               adc_done = 1'b0;
  logic [9:0]         adc_result = 10'h000;
  logic [7:0]         ctrl_wait = 8'h02;
  logic               tx_req;
  logic               tx_ctrl_sent;
  logic               tx_done;
  crio_pkg::crio_tx_t tx;
  crio_pkg::crio_tx_t last_tx;
  logic [15:0]        pin_out;
  logic [15:0]        pin_oe_n;
  logic [5:0]         sw_close;
  logic               adc_start;
  int                 n_mismatch = 0;
  int                 check_count = 0;
  logic [35:0]        tbl [0:10] = '{36'h1ffffffff, 36'h2ffffffff,
    36'h35a5a5a5a, 36'h4ffffffff, 36'h57fff07e0, 36'h6ffffffc0,
    36'h7ffffffc0, 36'h0beef1234, 36'h9beef0000, 36'h100080008,
    36'h200200020};

  always #5 core_clk = ~core_clk;

  crio_regs crio_regs_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .rx_valid(rx_valid), .rx(rx), .tx_req(tx_req),
    .tx_ctrl_sent(tx_ctrl_sent), .tx_done(tx_done), .tx(tx),
    .calibrated(calibrated), .mode_change(mode_change),
    .err_warn(err_warn), .bus_mode(bus_mode), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .cmp_in(cmp_in),
    .sw_close(sw_close),
    .adc_start(adc_start), .adc_done(adc_done), .adc_result(adc_result));

  crio_host_model crio_host_model_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .tx_req(tx_req), .tx(tx), .ctrl_wait(ctrl_wait),
    .tx_ctrl_sent(tx_ctrl_sent), .tx_done(tx_done), .last_tx(last_tx));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic send(input crio_pkg::crio_frame_t k, input logic [3:0] d,
                      input logic dr, input logic [3:0] a,
                      input logic [15:0] v);
    @(negedge core_clk);
    rx_valid = 1'b1;
    rx = '{kind: k, dlc: d, dir: dr, addr: a, value: v};
    @(negedge core_clk);
    rx_valid = 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    send(crio_pkg::CRIO_FR_DATA, crio_pkg::DLC_REG, 1'b0, a, v);
  endtask

  task automatic frame(input logic [3:0] a, input logic [15:0] v);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge core_clk);
      #1;
      if (tx_done === 1'b1)
        break;
    end
    chk(tx_done, 1'b1);
    chk({last_tx.addr, last_tx.value}, {a, v});
    @(negedge core_clk);
  endtask

  task automatic adc_cycle(input logic [9:0] r);
    int i;
    for (i = 0; i < 200; i++)
    begin
      if (adc_start === 1'b1)
        break;
      @(negedge core_clk);
    end
    chk(adc_start, 1'b1);
    @(negedge core_clk);
    adc_result = r;
    adc_done = 1'b1;
    @(negedge core_clk);
    adc_done = 1'b0;
  endtask

  task automatic count_hi(input int b, input logic [31:0] exp);
    int i;
    int n;
    n = 0;
    for (i = 0; i < 4096; i++)
    begin
      @(posedge core_clk);
      #1;
      n += $isunknown(pin_out[b]) ? 8192 : int'(pin_out[b]);
    end
    chk(n, exp);
  endtask

  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #1000000;
    n_mismatch++;
    results();
  end

  initial
  begin
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    chk(pin_oe_n, 16'hffff);
    chk(tx_req, 1'b0);
    @(negedge core_clk);
    calibrated = 1'b1;
    @(negedge core_clk);
    calibrated = 1'b0;
    frame(crio_pkg::ADDR_INPUT, 16'h1234);
    chk(last_tx.rstd, 1'b1);
    err_warn = 1'b1;
    bus_mode = 2'h2;
    send(crio_pkg::CRIO_FR_REMOTE, 4'h3, 1'b1, 4'h0, 16'h0000);
    frame(crio_pkg::ADDR_INPUT, 16'h1234);
    chk(last_tx.rstd, 1'b0);
    chk({last_tx.ew, last_tx.bm}, 3'h6);
    send(crio_pkg::CRIO_FR_DATA, 4'h4, 1'b0, 4'h3, 16'hffff);
    send(crio_pkg::CRIO_FR_DATA, 4'h3, 1'b1, 4'h3, 16'hffff);
    repeat (10) @(negedge core_clk);
    chk(tx_req, 1'b0);
    for (int k = 0; k < 11; k++)
    begin
      wr(tbl[k][35:32], tbl[k][31:16]);
      frame(tbl[k][35:32], tbl[k][15:0]);
    end
    chk(pin_oe_n, 16'h0000);
    for (int c = 0; c < 8; c++)
    begin
      wr(crio_pkg::ADDR_ANALOG, 16'(c << 5));
      frame(crio_pkg::ADDR_ANALOG, 16'(c << 5));
      chk(sw_close, (c == 0 || c == 7) ? 6'h00 : 6'h01 << (c - 1));
    end
    @(negedge core_clk);
    pin_in = 16'h123c;
    frame(crio_pkg::ADDR_INPUT, 16'h123c);
    ctrl_wait = 8'h28;
    @(negedge core_clk);
    pin_in = 16'h121c;
    repeat (5) @(negedge core_clk);
    pin_in = 16'h121d;
    frame(crio_pkg::ADDR_INPUT, 16'h121d);
    ctrl_wait = 8'h02;
    wr(crio_pkg::ADDR_ADC, 16'h0000);
    adc_cycle(10'h2a5);
    frame(crio_pkg::ADDR_ADC, 16'ha940);
    wr(crio_pkg::ADDR_ANALOG, 16'h8000);
    frame(crio_pkg::ADDR_ANALOG, 16'h8000);
    adc_cycle(10'h155);
    frame(crio_pkg::ADDR_ADC, 16'h5540);
    wr(crio_pkg::ADDR_ANALOG, 16'h0100);
    frame(crio_pkg::ADDR_ANALOG, 16'h0100);
    wr(crio_pkg::ADDR_RISE, 16'h0088);
    frame(crio_pkg::ADDR_RISE, 16'h0088);
    @(negedge core_clk);
    cmp_in = 3'h1;
    frame(crio_pkg::ADDR_ANALOG, 16'h1100);
    chk(pin_out[7], 1'b1);
    wr(crio_pkg::ADDR_OUT, 16'h0000);
    frame(crio_pkg::ADDR_OUT, 16'h0000);
    wr(crio_pkg::ADDR_PULSE_DAC_ONE, 16'h0040);
    frame(crio_pkg::ADDR_PULSE_DAC_ONE, 16'h0040);
    wr(crio_pkg::ADDR_PULSE_DAC_TWO, 16'h0080);
    frame(crio_pkg::ADDR_PULSE_DAC_TWO, 16'h0080);
    count_hi(crio_pkg::PIN_PULSE_DAC_ONE, 4);
    count_hi(crio_pkg::PIN_PULSE_DAC_TWO, 8);
    wr(crio_pkg::ADDR_OUT, 16'h0400);
    frame(crio_pkg::ADDR_OUT, 16'h0400);
    count_hi(crio_pkg::PIN_PULSE_DAC_ONE, 4092);
    @(negedge core_clk);
    mode_change = 1'b1;
    @(negedge core_clk);
    mode_change = 1'b0;
    repeat (8) @(negedge core_clk);
    chk(pin_oe_n, 16'hffff);
    chk(pin_out, 16'h0000);
    results();
  end
endmodule
